// >>> autoneg_next_page_regs.v
`include "np_regs_defs.vh"

// Behaviour
// - local next-page-able expansion bit always reads 1, read-only.
// - page-received flag sets on new partner page, latched until read, resets 0.
// - read-only bit shows partner auto-negotiation ability, resets 0.
// - writable second-acknowledge bit, 1 will comply; resets 0.
// - read-only local toggle reflects previous transmitted toggle; resets 0.
// - writable 11-bit local message field, resets to 001h.
// - partner word shows next-page-follows and message-page bits, read-only.
// - read-only partner acknowledge bit, 1 on successful receipt; resets 0.
// - read-only partner second-acknowledge bit; resets 0.
// - read-only partner toggle bit as received.
// - read-only 11-bit partner message field, resets to zero.
// - writable bit turns PLL off in energy-detect power-down; resets 0.
// - read-only bit shows partner next-page ability; resets 0.
module autoneg_next_page_regs #(
	parameter [4:0] PHY_ADDR = 5'h01
) (
	input wire clock,
	input wire rst_b,
	input wire mdc,
	input wire mdio_in,
	output wire mdio_out,
	output wire mdio_oe,
	input wire an_partner_able,
	input wire an_partner_np_able,
	input wire an_page_rx,
	input wire [15:0] an_rx_word,
	input wire an_tx_sent,
	input wire an_tx_toggle,
	output reg local_next_page_r,
	output reg local_message_page_r,
	output reg local_second_acknowledge_r,
	output reg [10:0] local_message_r,
	output reg local_page_loaded_r,
	output reg pll_off_in_energy_detect_power_down_r
);

	// reset release
	reg [1:0] rst_pipe_r;
	wire rst_sync_b = rst_pipe_r[1];

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_pipe_r <= 2'h0;
		end else begin
			rst_pipe_r <= {rst_pipe_r[0], 1'h1};
		end
	end

	// pin synchronisers: index 0 is mdc, index 1 is mdio
	wire [1:0] pin_raw = {mdio_in, mdc};
	wire [1:0] pin_sync;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
			reg s1_r;
			reg s2_r;
			always @(posedge clock or negedge rst_sync_b) begin
				if (!rst_sync_b) begin
					s1_r <= 1'h0;
					s2_r <= 1'h0;
				end else begin
					s1_r <= pin_raw[gi];
					s2_r <= s1_r;
				end
			end
			assign pin_sync[gi] = s2_r;
		end
	endgenerate

	// rising edge of the management clock, with the data bit aligned to it
	reg mdc_prev_r;
	reg bit_strobe_r;
	reg bit_val_r;

	always @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			mdc_prev_r <= 1'h0;
			bit_strobe_r <= 1'h0;
			bit_val_r <= 1'h0;
		end else begin
			mdc_prev_r <= pin_sync[0];
			bit_strobe_r <= pin_sync[0] & ~mdc_prev_r;
			bit_val_r <= pin_sync[1];
		end
	end

	// frame engine
	wire [4:0] reg_addr;
	wire rd_pulse;
	wire wr_pulse;
	wire [15:0] wr_data;
	reg [15:0] rd_data;

	mdio_frame_slave #(
		.PHY_ADDR(PHY_ADDR)
	) u_frame (
		.clock(clock),
		.rst_b(rst_sync_b),
		.bit_strobe(bit_strobe_r),
		.bit_in(bit_val_r),
		.rd_data(rd_data),
		.reg_addr_r(reg_addr),
		.rd_pulse_r(rd_pulse),
		.wr_pulse_r(wr_pulse),
		.wr_data_r(wr_data),
		.mdio_out_r(mdio_out),
		.mdio_oe_r(mdio_oe)
	);

	function addr_hit;
		input [4:0] addr;
		input [4:0] target;
		begin
			addr_hit = (addr == target);
		end
	endfunction

	wire rd_expansion = rd_pulse & addr_hit(reg_addr, `REG_AUTONEG_EXPANSION_STATUS);
	wire wr_local_np = wr_pulse & addr_hit(reg_addr, `REG_LOCAL_NEXT_PAGE_WORD);
	wire wr_dig_misc = wr_pulse & addr_hit(reg_addr, `REG_DIGITAL_MISC_CONTROL);
	wire wr_front_end = wr_pulse & addr_hit(reg_addr, `REG_FRONT_END_CONTROL_ONE);

	// partner page capture, local toggle and latched page flag
	wire [15:0] partner_word;
	wire local_toggle;
	wire page_received;

	np_page_tracker u_tracker (
		.clock(clock),
		.rst_b(rst_sync_b),
		.page_rx(an_page_rx),
		.rx_word(an_rx_word),
		.tx_sent(an_tx_sent),
		.tx_toggle(an_tx_toggle),
		.flag_clear(rd_expansion),
		.partner_word_r(partner_word),
		.local_toggle_r(local_toggle),
		.page_received_r(page_received)
	);

	// partner ability levels from the negotiation engine
	reg lp_an_able_r;
	reg lp_np_able_r;

	always @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			lp_an_able_r <= 1'h0;
			lp_np_able_r <= 1'h0;
		end else begin
			lp_an_able_r <= an_partner_able;
			lp_np_able_r <= an_partner_np_able;
		end
	end

	// local next-page word; load pulse tells the engine a new page is ready
	always @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			local_next_page_r <= `RST_LOCAL_NEXT_PAGE;
			local_message_page_r <= `RST_LOCAL_MESSAGE_PAGE;
			local_second_acknowledge_r <= `RST_LOCAL_SECOND_ACK;
			local_message_r <= `RST_LOCAL_MESSAGE;
			local_page_loaded_r <= 1'h0;
		end else begin
			local_page_loaded_r <= wr_local_np;
			if (wr_local_np) begin
				local_next_page_r <= wr_data[`NP_NEXT_PAGE];
				local_message_page_r <= wr_data[`NP_MESSAGE_PAGE];
				local_second_acknowledge_r <= wr_data[`NP_SECOND_ACK];
				local_message_r <= wr_data[`NP_MSG_HI:`NP_MSG_LO];
			end
		end
	end

	// digital misc control, all bits writable
	reg [15:0] dig_misc_r;

	always @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			dig_misc_r <= `RST_DIGITAL_MISC;
			pll_off_in_energy_detect_power_down_r <= 1'h0;
		end else begin
			if (wr_dig_misc) begin
				dig_misc_r <= wr_data;
				pll_off_in_energy_detect_power_down_r <= wr_data[`DIG_PLL_OFF];
			end
		end
	end

	// front end control: only the upper reserved field is held here
	reg [9:0] front_end_rsvd_r;

	always @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			front_end_rsvd_r <= `RST_FRONT_END_RSVD;
		end else if (wr_front_end) begin
			front_end_rsvd_r <= wr_data[`AFE_RSVD_HI:`AFE_RSVD_LO];
		end
	end

	// read data; unmapped registers read zero
	always @* begin
		rd_data = 16'h0000;
		case (reg_addr)
		`REG_AUTONEG_EXPANSION_STATUS: begin
			rd_data[`EXP_LP_NP_ABLE] = lp_np_able_r;
			rd_data[`EXP_LOCAL_NP_ABLE] = 1'h1;
			rd_data[`EXP_PAGE_RECEIVED] = page_received;
			rd_data[`EXP_LP_AN_ABLE] = lp_an_able_r;
		end
		`REG_LOCAL_NEXT_PAGE_WORD: begin
			rd_data[`NP_NEXT_PAGE] = local_next_page_r;
			rd_data[`NP_MESSAGE_PAGE] = local_message_page_r;
			rd_data[`NP_SECOND_ACK] = local_second_acknowledge_r;
			rd_data[`NP_TOGGLE] = local_toggle;
			rd_data[`NP_MSG_HI:`NP_MSG_LO] = local_message_r;
		end
		`REG_PARTNER_NEXT_PAGE_WORD: begin
			rd_data = partner_word;
		end
		`REG_DIGITAL_MISC_CONTROL: begin
			rd_data = dig_misc_r;
		end
		`REG_FRONT_END_CONTROL_ONE: begin
			rd_data[`AFE_RSVD_HI:`AFE_RSVD_LO] = front_end_rsvd_r;
		end
		default: begin
			rd_data = 16'h0000;
		end
		endcase
	end

endmodule // autoneg_next_page_regs

// >>> np_regs_defs.vh
`ifndef NP_REGS_DEFS_VH
`define NP_REGS_DEFS_VH

// management register numbers
`define REG_AUTONEG_EXPANSION_STATUS 5'h06
`define REG_LOCAL_NEXT_PAGE_WORD 5'h07
`define REG_PARTNER_NEXT_PAGE_WORD 5'h08
`define REG_DIGITAL_MISC_CONTROL 5'h10
`define REG_FRONT_END_CONTROL_ONE 5'h11

// expansion status fields
`define EXP_LP_NP_ABLE 3
`define EXP_LOCAL_NP_ABLE 2
`define EXP_PAGE_RECEIVED 1
`define EXP_LP_AN_ABLE 0

// next-page word fields, shared by local and partner words
`define NP_NEXT_PAGE 15
`define NP_ACKNOWLEDGE 14
`define NP_MESSAGE_PAGE 13
`define NP_SECOND_ACK 12
`define NP_TOGGLE 11
`define NP_MSG_HI 10
`define NP_MSG_LO 0

// digital misc control and front end fields
`define DIG_PLL_OFF 4
`define AFE_RSVD_HI 15
`define AFE_RSVD_LO 6

// reset values
`define RST_LOCAL_NEXT_PAGE 1'h0
`define RST_LOCAL_MESSAGE_PAGE 1'h1
`define RST_LOCAL_SECOND_ACK 1'h0
`define RST_LOCAL_MESSAGE 11'h001
`define RST_PARTNER_WORD 16'h0000
`define RST_DIGITAL_MISC 16'h0000
`define RST_FRONT_END_RSVD 10'h000

// serial management frame
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`define MDIO_PREAMBLE_BITS 6'h20
`define MDIO_HEADER_LAST 6'h0B
`define MDIO_DATA_LAST 6'h0F

`endif

// >>> np_page_tracker.v
`include "np_regs_defs.vh"

module np_page_tracker (
	input wire clock,
	input wire rst_b,
	input wire page_rx,
	input wire [15:0] rx_word,
	input wire tx_sent,
	input wire tx_toggle,
	input wire flag_clear,
	output reg [15:0] partner_word_r,
	output reg local_toggle_r,
	output reg page_received_r
);

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			partner_word_r <= `RST_PARTNER_WORD;
			local_toggle_r <= 1'h0;
			page_received_r <= 1'h0;
		end else begin
			// partner word captured whole when a page arrives
			if (page_rx) begin
				partner_word_r <= rx_word;
			end
			// toggle of the last link code word sent
			if (tx_sent) begin
				local_toggle_r <= tx_toggle;
			end
			// latched high; a new page in the clearing read cycle wins
			if (page_rx) begin
				page_received_r <= 1'h1;
			end else if (flag_clear) begin
				page_received_r <= 1'h0;
			end
		end
	end

endmodule // np_page_tracker

// >>> mdio_frame_slave.v
`include "np_regs_defs.vh"

module mdio_frame_slave #(
	parameter [4:0] PHY_ADDR = 5'h01
) (
	input wire clock,
	input wire rst_b,
	input wire bit_strobe,
	input wire bit_in,
	input wire [15:0] rd_data,
	output reg [4:0] reg_addr_r,
	output reg rd_pulse_r,
	output reg wr_pulse_r,
	output reg [15:0] wr_data_r,
	output reg mdio_out_r,
	output reg mdio_oe_r
);

	localparam [2:0] S_PRE = 3'h0;
	localparam [2:0] S_ST = 3'h1;
	localparam [2:0] S_HDR = 3'h2;
	localparam [2:0] S_TA = 3'h3;
	localparam [2:0] S_RDAT = 3'h4;
	localparam [2:0] S_WDAT = 3'h5;

	reg [2:0] state_r;
	reg [5:0] cnt_r;
	reg [10:0] hdr_r;
	reg [15:0] shift_r;
	reg is_read_r;
	wire [11:0] hdr_full = {hdr_r, bit_in};

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= S_PRE;
			cnt_r <= 6'h00;
			hdr_r <= 11'h000;
			shift_r <= 16'h0000;
			is_read_r <= 1'h0;
			reg_addr_r <= 5'h00;
			rd_pulse_r <= 1'h0;
			wr_pulse_r <= 1'h0;
			wr_data_r <= 16'h0000;
			mdio_out_r <= 1'h0;
			mdio_oe_r <= 1'h0;
		end else begin
			rd_pulse_r <= 1'h0;
			wr_pulse_r <= 1'h0;
			// read data snapshot the cycle after the header is decoded
			if (rd_pulse_r) begin
				shift_r <= rd_data;
			end
			if (bit_strobe) begin
				case (state_r)
				S_PRE: begin
					if (bit_in) begin
						if (cnt_r != `MDIO_PREAMBLE_BITS) begin
							cnt_r <= cnt_r + 6'h01;
						end
					end else if (cnt_r == `MDIO_PREAMBLE_BITS) begin
						state_r <= S_ST;
						cnt_r <= 6'h00;
					end else begin
						cnt_r <= 6'h00;
					end
				end
				S_ST: begin
					state_r <= bit_in ? S_HDR : S_PRE;
					cnt_r <= 6'h00;
				end
				S_HDR: begin
					hdr_r <= hdr_full[10:0];
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r == `MDIO_HEADER_LAST) begin
						cnt_r <= 6'h00;
						reg_addr_r <= hdr_full[4:0];
						if (hdr_full[9:5] == PHY_ADDR && hdr_full[11:10] == `MDIO_OP_READ) begin
							state_r <= S_TA;
							is_read_r <= 1'h1;
							rd_pulse_r <= 1'h1;
						end else if (hdr_full[9:5] == PHY_ADDR &&
							hdr_full[11:10] == `MDIO_OP_WRITE) begin
							state_r <= S_TA;
							is_read_r <= 1'h0;
						end else begin
							state_r <= S_PRE;
						end
					end
				end
				S_TA: begin
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r == 6'h00) begin
						// second turnaround bit driven low on reads
						if (is_read_r) begin
							mdio_oe_r <= 1'h1;
							mdio_out_r <= 1'h0;
						end
					end else begin
						cnt_r <= 6'h00;
						if (is_read_r) begin
							mdio_out_r <= shift_r[15];
							shift_r <= {shift_r[14:0], 1'h0};
							state_r <= S_RDAT;
						end else begin
							state_r <= S_WDAT;
						end
					end
				end
				S_RDAT: begin
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r == `MDIO_DATA_LAST) begin
						mdio_oe_r <= 1'h0;
						mdio_out_r <= 1'h0;
						state_r <= S_PRE;
						cnt_r <= 6'h00;
					end else begin
						mdio_out_r <= shift_r[15];
						shift_r <= {shift_r[14:0], 1'h0};
					end
				end
				S_WDAT: begin
					shift_r <= {shift_r[14:0], bit_in};
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r == `MDIO_DATA_LAST) begin
						wr_data_r <= {shift_r[14:0], bit_in};
						wr_pulse_r <= 1'h1;
						state_r <= S_PRE;
						cnt_r <= 6'h00;
					end
				end
				default: begin
					state_r <= S_PRE;
					cnt_r <= 6'h00;
				end
				endcase
			end
		end
	end

endmodule // mdio_frame_slave

// >>> autoneg_next_page_regs_monitor.sv
module autoneg_next_page_regs_monitor (
	input wire clock,
	input wire rst_b,
	input wire mdio_out,
	input wire mdio_oe,
	input wire local_next_page_r,
	input wire local_message_page_r,
	input wire local_second_acknowledge_r,
	input wire [10:0] local_message_r,
	input wire local_page_loaded_r,
	input wire pll_off_in_energy_detect_power_down_r
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	wire [13:0] word = {local_next_page_r, local_message_page_r,
		local_second_acknowledge_r, local_message_r};
	sequence s_ta;
		$rose(mdio_oe) && !mdio_out;
	endsequence
	sequence s_drive_hold;
		mdio_oe [*8];
	endsequence
	property p_reset_page;
		$rose(rst_b) |-> local_message_page_r && local_message_r == 11'h001;
	endproperty
	property p_reset_misc;
		$rose(rst_b) |-> !local_second_acknowledge_r && !pll_off_in_energy_detect_power_down_r;
	endproperty
	property p_loaded_cause;
		!$stable(word) |-> ##[0:1] local_page_loaded_r;
	endproperty
	property p_loaded_pulse;
		local_page_loaded_r |=> !local_page_loaded_r;
	endproperty
	property p_loaded_quiet;
		local_page_loaded_r |-> !mdio_oe;
	endproperty
	property p_ta_zero;
		$rose(mdio_oe) |-> s_ta;
	endproperty
	property p_oe_hold;
		s_ta |=> s_drive_hold;
	endproperty
	property p_pll_quiet;
		!$stable(pll_off_in_energy_detect_power_down_r) |-> !mdio_oe;
	endproperty
	a_reset_page: assert property (p_reset_page) else $error("page reset wrong");
	a_reset_misc: assert property (p_reset_misc) else $error("misc reset wrong");
	a_loaded_cause: assert property (p_loaded_cause) else $error("no load pulse");
	a_loaded_pulse: assert property (p_loaded_pulse) else $error("load pulse long");
	a_loaded_quiet: assert property (p_loaded_quiet) else $error("load during read");
	a_ta_zero: assert property (p_ta_zero) else $error("turnaround not 0");
	a_oe_hold: assert property (p_oe_hold) else $error("drive too short");
	a_pll_quiet: assert property (p_pll_quiet) else $error("pll bit moved");
endmodule // autoneg_next_page_regs_monitor

// >>> mdio_station.sv
module mdio_station (
	input wire clock,
	input wire mdio_out,
	input wire mdio_oe,
	output logic mdc,
	output wire mdio_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drv = 1'b0;
	logic dbit = 1'b1;
	initial mdc = 1'b0;
	// released line is pulled up
	assign mdio_in = drv ? dbit : (mdio_oe ? mdio_out : 1'b1);
	task automatic bitx(input logic b, input logic d, output logic s);
		@(negedge clock);
		drv = d;
		dbit = b;
		mdc = 1'b0;
		repeat (4) @(negedge clock);
		s = mdio_in;
		mdc = 1'b1;
		repeat (3) @(negedge clock);
	endtask
	task automatic hdr(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra);
		logic s;
		logic [13:0] h;
		h = {2'b01, op, pa, ra};
		repeat (32) bitx(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--) bitx(h[i], 1'b1, s);
	endtask
	task automatic rd(input logic [4:0] ra, output logic [15:0] d);
		logic s;
		hdr(2'h2, 5'h01, ra);
		bitx(1'b1, 1'b0, s);
		bitx(1'b1, 1'b0, s);
		for (int i = 15; i >= 0; i--) bitx(1'b1, 1'b0, d[i]);
		bitx(1'b1, 1'b0, s);
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		frame_wr(2'h1, 5'h01, ra, d);
	endtask
	// write-shaped frame with any opcode and phy address, for refused frames
	task automatic frame_wr(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] d);
		logic s;
		hdr(op, pa, ra);
		bitx(1'b1, 1'b1, s);
		bitx(1'b0, 1'b1, s);
		for (int i = 15; i >= 0; i--) bitx(d[i], 1'b1, s);
		bitx(1'b1, 1'b0, s);
	endtask
endmodule // mdio_station

// >>> autoneg_next_page_regs_tb.sv
module autoneg_next_page_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic able = 1'b0;
	logic np_able = 1'b0;
	logic page_rx = 1'b0;
	logic [15:0] rx_word = 16'h0000;
	logic tx_sent = 1'b0;
	logic tx_toggle = 1'b0;
	wire mdc, mdio_in, mdio_out, mdio_oe, lnp, lmp, lsa, loaded, pll;
	wire [10:0] lmsg;
	logic [15:0] rd_val;
	int miscompares = 0;
	int checks = 0;
	int loads = 0;
	always @(posedge clock) begin
		if (loaded === 1'b1)
			loads++;
	end
	always #4 clock = ~clock;
	autoneg_next_page_regs u_autoneg_next_page_regs (.clock(clock), .rst_b(rst_b),
		.mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.an_partner_able(able), .an_partner_np_able(np_able), .an_page_rx(page_rx),
		.an_rx_word(rx_word), .an_tx_sent(tx_sent), .an_tx_toggle(tx_toggle),
		.local_next_page_r(lnp), .local_message_page_r(lmp),
		.local_second_acknowledge_r(lsa), .local_message_r(lmsg),
		.local_page_loaded_r(loaded), .pll_off_in_energy_detect_power_down_r(pll));
	mdio_station u_mdio_station (.clock(clock), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.mdc(mdc), .mdio_in(mdio_in));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task rchk(input logic [4:0] ra, input logic [15:0] exp);
		u_mdio_station.rd(ra, rd_val);
		chk(rd_val, exp);
	endtask
	task t_reset_values;
		rchk(5'h06, 16'h0004);
		rchk(5'h07, 16'h2001);
		rchk(5'h08, 16'h0000);
		rchk(5'h10, 16'h0000);
		$display("reset values done");
	endtask
	task t_local_word;
		u_mdio_station.wr(5'h07, 16'hFFFF);
		rchk(5'h07, 16'hB7FF);
		chk({lnp, 1'b0, lmp, lsa, 1'b0, lmsg}, 16'hB7FF);
		u_mdio_station.wr(5'h07, 16'h0000);
		rchk(5'h07, 16'h0000);
		chk(16'(loads), 16'h0002);
		@(negedge clock);
		tx_toggle = 1'b1;
		tx_sent = 1'b1;
		@(negedge clock);
		tx_sent = 1'b0;
		rchk(5'h07, 16'h0800);
		$display("local word done");
	endtask
	task t_partner_word;
		@(negedge clock);
		able = 1'b1;
		np_able = 1'b1;
		rx_word = 16'hD5A5;
		page_rx = 1'b1;
		@(negedge clock);
		page_rx = 1'b0;
		rchk(5'h06, 16'h000F);
		rchk(5'h06, 16'h000D);
		u_mdio_station.wr(5'h08, 16'h0000);
		rchk(5'h08, 16'hD5A5);
		able = 1'b0;
		rchk(5'h06, 16'h000C);
		$display("partner word done");
	endtask
	task t_pll_control;
		u_mdio_station.wr(5'h10, 16'h0010);
		chk({15'h0000, pll}, 16'h0001);
		rchk(5'h10, 16'h0010);
		u_mdio_station.wr(5'h10, 16'h0000);
		chk({15'h0000, pll}, 16'h0000);
		u_mdio_station.frame_wr(2'h1, 5'h02, 5'h10, 16'hFFFF);
		u_mdio_station.frame_wr(2'h3, 5'h01, 5'h10, 16'hFFFF);
		rchk(5'h10, 16'h0000);
		u_mdio_station.wr(5'h11, 16'hFFFF);
		rchk(5'h11, 16'hFFC0);
		rchk(5'h1F, 16'h0000);
		$display("pll control done");
	endtask
	task conclude;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clock);
		rst_b = 1'b1;
		repeat (10) @(negedge clock);
		t_reset_values;
		t_local_word;
		t_partner_word;
		t_pll_control;
		conclude;
	end
	initial begin
		#400000;
		miscompares++;
		conclude;
	end
endmodule // autoneg_next_page_regs_tb

bind autoneg_next_page_regs autoneg_next_page_regs_monitor u_autoneg_next_page_regs_monitor (
	.clock(clock), .rst_b(rst_b), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
	.local_next_page_r(local_next_page_r), .local_message_page_r(local_message_page_r),
	.local_second_acknowledge_r(local_second_acknowledge_r),
	.local_message_r(local_message_r), .local_page_loaded_r(local_page_loaded_r),
	.pll_off_in_energy_detect_power_down_r(pll_off_in_energy_detect_power_down_r));
